// >>> inc/grac_pkg.sv
// constants shared by the region access checker
`default_nettype none
package grac_pkg;
  // address split of the peripheral space
  localparam int REGION_COUNT = 16;
  localparam int REGION_IMPL = 2;
  localparam int REGION_SEL_LSB = 26;
  localparam int REGION_SEL_MSB = 29;
  localparam int MASTER_COUNT = 3;

  // register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] OFS_REGION0 = 8'h00;
  localparam logic [7:0] OFS_REGION1 = 8'h04;
  localparam logic [7:0] OFS_EVENT_STATUS = 8'h08;
  localparam logic [7:0] OFS_EVENT_MASK = 8'h0C;

  // region permission register layout
  localparam int PERM_LOCK_BIT = 7;
  localparam int PERM_CODE_MSB = 3;
  localparam logic [7:0] PERM_WRITABLE = 8'h8F;
  // supervisor read/write, user none, no execute, unlocked
  localparam logic [7:0] PERM_RESET = 8'h00;

  // event status bits
  localparam int EVT_WIDTH = 3;
  localparam int EVT_DENIED = 0;
  localparam int EVT_LOCKED_WR = 1;
  localparam int EVT_UNTRUSTED_WR = 2;
  localparam logic [2:0] EVT_RESET = 3'h0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    GRAC_WR_COLLECT = 2'b01,
    GRAC_WR_RESP = 2'b10
  } grac_wr_state_t;

  typedef enum logic [1:0] {
    GRAC_RD_IDLE = 2'b01,
    GRAC_RD_RESP = 2'b10
  } grac_rd_state_t;
endpackage : grac_pkg
`default_nettype wire

// >>> core/grac_perm_decode.sv
// permission code to access rights for both privilege levels
`default_nettype none
module grac_perm_decode
  import grac_pkg::*;
(
  input wire logic [3:0] code,
  output logic sup_rd,
  output logic sup_wr,
  output logic sup_ex,
  output logic usr_rd,
  output logic usr_wr,
  output logic usr_ex
);
  logic [5:0] rights;

  // order: supervisor r,w,x then user r,w,x
  always_comb begin
    case (code)
      4'h0: rights = 6'b110000; // R9
      4'h1: rights = 6'b100000; // R10
      4'h2: rights = 6'b100100; // R10
      4'h3: rights = 6'b100000; // R10
      4'h4: rights = 6'b110110; // R9
      4'h5: rights = 6'b110100; // R10
      4'h6: rights = 6'b110110; // R9
      4'h7: rights = 6'b000000; // R9
      4'h8: rights = 6'b111000; // R11
      4'h9: rights = 6'b101000; // R11
      4'hA: rights = 6'b101101; // R11
      4'hB: rights = 6'b001000; // R11
      4'hC: rights = 6'b111111; // R11
      4'hD: rights = 6'b111101; // R12
      4'hE: rights = 6'b110100; // R12
      4'hF: rights = 6'b111001; // R12
      default: rights = 6'b000000;
    endcase
  end

  assign sup_rd = rights[5];
  assign sup_wr = rights[4];
  assign sup_ex = rights[3];
  assign usr_rd = rights[2];
  assign usr_wr = rights[1];
  assign usr_ex = rights[0];
endmodule : grac_perm_decode
`default_nettype wire

// >>> core/grac_top.sv
// region access checker with AXI4-Lite register slave
// Notes on behaviour
// R1: sixteen 64-Mbyte regions; address bits 29..26 pick the region.
// R2: only regions 0 and 1 own a permission register.
// R3: regions 2 to 15 are reserved and have no register.
// R4: per-module covered accesses use only the per-module verdict.
// R5: permission registers are 8 bits giving read, write, execute rights.
// R6: once lock bit 7 is set, writes error and change nothing.
// R7: only reset clears the lock bit.
// R8: software keeps bits 6 to 4 zero; they read zero.
// R9: codes 0-7 never execute; 0,6,4,7 as listed.
// R10: codes 1,3 supervisor read; 2 read both; 5 user read.
// R11: codes 8 to 12 grant the listed execute-capable rights.
// R12: codes 13 to 15 grant the listed mixed rights.
// R13: after reset regions allow supervisor read/write only.
// R14: user access to supervisor-only space errors and has no effect.
// R15: untrusted writes to control registers error; value kept.
// R16: privilege bit 0 forces user mode; 1 uses access attribute.
// R17: access type mismatching region rights errors with no side effect.
// R18: reserved-region accesses are flagged and left to outer decoding.
`default_nettype none
module grac_top
  import grac_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cfg_master_trusted,
  input wire logic [2:0] master_privilege_bits,
  input wire logic chk_valid,
  input wire logic [31:0] chk_addr,
  input wire logic [1:0] chk_master,
  input wire logic chk_supervisor,
  input wire logic chk_write,
  input wire logic chk_exec,
  input wire logic per_module_hit,
  input wire logic per_module_allow,
  output logic chk_done,
  output logic chk_grant,
  output logic chk_error,
  output logic chk_reserved,
  output logic irq
);
  grac_wr_state_t wr_state_reg, wr_state_next;
  grac_rd_state_t rd_state_reg, rd_state_next;
  logic aw_have_reg, aw_have_next;
  logic w_have_reg, w_have_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic aw_trusted_reg, aw_trusted_next;
  logic [7:0] wdata_reg, wdata_next;
  logic wstrb0_reg, wstrb0_next;
  logic [1:0] bresp_reg, bresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [7:0] perm_reg [REGION_IMPL];
  logic [7:0] perm_next [REGION_IMPL];
  logic [EVT_WIDTH-1:0] status_reg, status_next;
  logic [EVT_WIDTH-1:0] mask_reg, mask_next;
  logic done_reg, grant_reg, error_reg, reserved_reg;
  logic done_next, grant_next, error_next, reserved_next;
  logic commit;
  logic [EVT_WIDTH-1:0] evt_set;
  logic [3:0] region;
  logic eff_super;
  logic [REGION_IMPL-1:0] ok_vec;

  // rights per implemented region
  genvar g;
  generate
    for (g = 0; g < REGION_IMPL; g++) begin : g_region
      logic sr, sw, sx, ur, uw, ux;
      grac_perm_decode u_dec (
        .code(perm_reg[g][PERM_CODE_MSB:0]), .sup_rd(sr), .sup_wr(sw),
        .sup_ex(sx), .usr_rd(ur), .usr_wr(uw), .usr_ex(ux)
      );
      // fetches need execute, data needs read or write
      assign ok_vec[g] = chk_exec ? (eff_super ? sx : ux) :
                         chk_write ? (eff_super ? sw : uw) :
                         (eff_super ? sr : ur); // R17 R5
    end
  endgenerate

  assign region = chk_addr[REGION_SEL_MSB:REGION_SEL_LSB]; // R1
  assign eff_super = master_privilege_bits[chk_master] & chk_supervisor; // R16

  // access check, one cycle after the request
  always_comb begin
    done_next = chk_valid;
    grant_next = 1'b0;
    error_next = 1'b0;
    reserved_next = 1'b0;
    if (chk_valid) begin
      if (per_module_hit) begin
        grant_next = per_module_allow; // R4
        error_next = !per_module_allow;
      end else if (region < 4'(REGION_IMPL)) begin // R2
        grant_next = ok_vec[region[0]]; // R17
        error_next = !ok_vec[region[0]]; // R14
      end else begin
        reserved_next = 1'b1; // R3 R18
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      {done_reg, grant_reg, error_reg, reserved_reg} <= 4'h0;
    end else begin
      {done_reg, grant_reg, error_reg, reserved_reg} <=
          {done_next, grant_next, error_next, reserved_next};
    end
  end
  assign chk_done = done_reg;
  assign chk_grant = grant_reg;
  assign chk_error = error_reg;
  assign chk_reserved = reserved_reg;

  // write channel: address and data may arrive in either order
  assign s_axi_awready = (wr_state_reg == GRAC_WR_COLLECT) && !aw_have_reg;
  assign s_axi_wready = (wr_state_reg == GRAC_WR_COLLECT) && !w_have_reg;
  assign commit = (wr_state_reg == GRAC_WR_COLLECT) && aw_have_reg &&
                  w_have_reg;

  always_comb begin
    wr_state_next = wr_state_reg;
    aw_have_next = aw_have_reg;
    w_have_next = w_have_reg;
    awaddr_next = awaddr_reg;
    aw_trusted_next = aw_trusted_reg;
    wdata_next = wdata_reg;
    wstrb0_next = wstrb0_reg;
    bresp_next = bresp_reg;
    for (int i = 0; i < REGION_IMPL; i++) begin
      perm_next[i] = perm_reg[i];
    end
    mask_next = mask_reg;
    status_next = status_reg;
    evt_set = '0;
    if (chk_valid && !per_module_hit && region < 4'(REGION_IMPL) &&
        !ok_vec[region[0]]) begin
      evt_set[EVT_DENIED] = 1'b1;
    end
    case (wr_state_reg)
      GRAC_WR_COLLECT: begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_have_next = 1'b1;
          awaddr_next = s_axi_awaddr;
          aw_trusted_next = cfg_master_trusted;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_have_next = 1'b1;
          wdata_next = s_axi_wdata[7:0];
          wstrb0_next = s_axi_wstrb[0];
        end
        if (commit) begin
          aw_have_next = 1'b0;
          w_have_next = 1'b0;
          wr_state_next = GRAC_WR_RESP;
          bresp_next = RESP_OKAY;
          if (awaddr_reg > OFS_EVENT_MASK || awaddr_reg[1:0] != 2'h0) begin
            bresp_next = RESP_DECERR;
          end else if (!aw_trusted_reg) begin
            bresp_next = RESP_SLVERR; // R15
            evt_set[EVT_UNTRUSTED_WR] = 1'b1;
          end else if (awaddr_reg[3]) begin
            if (wstrb0_reg && awaddr_reg[2]) begin
              mask_next = wdata_reg[EVT_WIDTH-1:0];
            end else if (wstrb0_reg) begin
              // write-one-to-clear
              status_next = status_reg & ~wdata_reg[EVT_WIDTH-1:0];
            end
          end else if (perm_reg[awaddr_reg[2]][PERM_LOCK_BIT]) begin
            bresp_next = RESP_SLVERR; // R6
            evt_set[EVT_LOCKED_WR] = 1'b1;
          end else if (wstrb0_reg) begin
            // reserved bits never stored; lock can only be set
            perm_next[awaddr_reg[2]] = wdata_reg & PERM_WRITABLE; // R8 R7
          end
        end
      end
      GRAC_WR_RESP: begin
        if (s_axi_bready) begin
          wr_state_next = GRAC_WR_COLLECT;
        end
      end
      default: wr_state_next = GRAC_WR_COLLECT;
    endcase
    // an event in the same cycle as a clear stays set
    status_next = status_next | evt_set;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_state_reg <= GRAC_WR_COLLECT;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      aw_trusted_reg <= 1'b0;
      wdata_reg <= 8'h00;
      wstrb0_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      for (int i = 0; i < REGION_IMPL; i++) begin
        perm_reg[i] <= PERM_RESET; // R13 R7
      end
      status_reg <= EVT_RESET;
      mask_reg <= EVT_RESET;
    end else begin
      wr_state_reg <= wr_state_next;
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      awaddr_reg <= awaddr_next;
      aw_trusted_reg <= aw_trusted_next;
      wdata_reg <= wdata_next;
      wstrb0_reg <= wstrb0_next;
      bresp_reg <= bresp_next;
      for (int i = 0; i < REGION_IMPL; i++) begin
        perm_reg[i] <= perm_next[i];
      end
      status_reg <= status_next;
      mask_reg <= mask_next;
    end
  end

  assign s_axi_bvalid = (wr_state_reg == GRAC_WR_RESP);
  assign s_axi_bresp = bresp_reg;
  assign irq = |(status_reg & mask_reg);

  // read channel: one outstanding read, data registered
  assign s_axi_arready = (rd_state_reg == GRAC_RD_IDLE);

  always_comb begin
    rd_state_next = rd_state_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    case (rd_state_reg)
      GRAC_RD_IDLE: begin
        if (s_axi_arvalid) begin
          rd_state_next = GRAC_RD_RESP;
          rresp_next = RESP_OKAY;
          rdata_next = 32'h0000_0000;
          case (s_axi_araddr)
            OFS_REGION0: rdata_next[7:0] = perm_reg[0];
            OFS_REGION1: rdata_next[7:0] = perm_reg[1];
            OFS_EVENT_STATUS: rdata_next[EVT_WIDTH-1:0] = status_reg;
            OFS_EVENT_MASK: rdata_next[EVT_WIDTH-1:0] = mask_reg;
            default: rresp_next = RESP_DECERR;
          endcase
        end
      end
      GRAC_RD_RESP: begin
        if (s_axi_rready) begin
          rd_state_next = GRAC_RD_IDLE;
        end
      end
      default: rd_state_next = GRAC_RD_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rd_state_reg <= GRAC_RD_IDLE;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end else begin
      rd_state_reg <= rd_state_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  assign s_axi_rvalid = (rd_state_reg == GRAC_RD_RESP);
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  lock_sticky_a: assert property ( // R7
    @(posedge clk) disable iff (!reset_n)
    perm_reg[0][PERM_LOCK_BIT] |=> perm_reg[0][PERM_LOCK_BIT])
    else $error("region 0 lock bit cleared without reset");
  locked_write_a: assert property ( // R6
    @(posedge clk) disable iff (!reset_n)
    commit && aw_trusted_reg && awaddr_reg == OFS_REGION0 &&
    perm_reg[0][PERM_LOCK_BIT]
    |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR &&
        perm_reg[0] == $past(perm_reg[0]))
    else $error("locked region write not refused");
  untrusted_write_a: assert property ( // R15
    @(posedge clk) disable iff (!reset_n)
    commit && !aw_trusted_reg && awaddr_reg == OFS_REGION1
    |=> s_axi_bresp == RESP_SLVERR && $stable(perm_reg[1]))
    else $error("untrusted write changed a region register");
  reset_value_a: assert property ( // R13
    @(posedge clk) $past(!reset_n) && reset_n
    |-> perm_reg[0] == PERM_RESET && perm_reg[1] == PERM_RESET)
    else $error("region register not at reset value");
  reserved_bits_a: assert property ( // R8
    @(posedge clk) disable iff (!reset_n)
    perm_reg[0][6:4] == 3'h0 && perm_reg[1][6:4] == 3'h0)
    else $error("reserved permission bits not zero");
  user_denied_a: assert property ( // R14
    @(posedge clk) disable iff (!reset_n)
    chk_valid && !per_module_hit && region == 4'h0 && !eff_super &&
    perm_reg[0][PERM_CODE_MSB:0] == 4'h0
    |=> chk_done && chk_error && !chk_grant)
    else $error("user access to supervisor-only region granted");
  priv_force_a: assert property ( // R16
    @(posedge clk) disable iff (!reset_n)
    chk_valid && !per_module_hit && region == 4'h1 &&
    !master_privilege_bits[chk_master] &&
    perm_reg[1][PERM_CODE_MSB:0] == 4'h1
    |=> chk_error)
    else $error("master without privilege treated as supervisor");
  per_module_a: assert property ( // R4
    @(posedge clk) disable iff (!reset_n)
    chk_valid && per_module_hit
    |=> chk_grant == $past(per_module_allow) && !chk_reserved)
    else $error("per-module verdict not followed");
  reserved_region_a: assert property ( // R18
    @(posedge clk) disable iff (!reset_n)
    chk_valid && !per_module_hit && region >= 4'h2
    |=> chk_reserved && !chk_grant && !chk_error)
    else $error("reserved region access not flagged");
  no_exec_low_a: assert property ( // R9
    @(posedge clk) disable iff (!reset_n)
    chk_valid && chk_exec && !per_module_hit && region == 4'h0 &&
    !perm_reg[0][PERM_CODE_MSB]
    |=> chk_error)
    else $error("execute allowed by a non-execute code");
endmodule : grac_top
`default_nettype wire

// >>> verif/grac_master_model.sv
// bus master model issuing peripheral accesses to the checker
`default_nettype none
module grac_master_model (
  input wire logic clk,
  output var logic chk_valid,
  output var logic [31:0] chk_addr,
  output var logic [1:0] chk_master,
  output var logic chk_supervisor,
  output var logic chk_write,
  output var logic chk_exec,
  input wire logic chk_done,
  input wire logic chk_grant,
  input wire logic chk_error,
  input wire logic chk_reserved
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    chk_valid = 1'b0;
    chk_addr = 32'h0;
    chk_master = 2'h0;
    chk_supervisor = 1'b0;
    chk_write = 1'b0;
    chk_exec = 1'b0;
  end
  // one access; v = {done, grant, error, reserved} one cycle later
  task access(input logic [31:0] a, input logic [1:0] m,
              input logic s, w, x, output logic [3:0] v);
    @(posedge clk);
    chk_valid <= 1'b1;
    chk_addr <= a;
    chk_master <= m;
    chk_supervisor <= s;
    chk_write <= w;
    chk_exec <= x;
    @(posedge clk);
    chk_valid <= 1'b0;
    // released fields must not look like a held access
    chk_addr <= ~a;
    chk_write <= ~w;
    #1 v = {chk_done, chk_grant, chk_error, chk_reserved};
  endtask : access
endmodule : grac_master_model
`default_nettype wire

// >>> verif/grac_top_tb_top.sv
// self-checking bench for the region access checker
`default_nettype none
module grac_top_tb_top import grac_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h0;
  logic [7:0] s_axi_araddr = 8'h0;
  logic [2:0] s_axi_awprot = 3'h0;
  logic [2:0] s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic cfg_master_trusted = 1'b1;
  logic [2:0] master_privilege_bits = 3'h7;
  logic per_module_hit = 1'b0;
  logic per_module_allow = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq, chk_valid, chk_supervisor, chk_write, chk_exec;
  logic chk_done, chk_grant, chk_error, chk_reserved;
  logic [1:0] s_axi_bresp, s_axi_rresp, chk_master;
  logic [31:0] s_axi_rdata, chk_addr;
  int n_mismatch = 0;
  int cmp_count = 0;
  // rights per code as {sup r, w, x, user r, w, x}
  localparam logic [5:0] RT [16] = '{6'h30, 6'h20, 6'h24, 6'h20, 6'h36,
    6'h34, 6'h36, 6'h00, 6'h38, 6'h28, 6'h2D, 6'h08, 6'h3F, 6'h3D, 6'h34,
    6'h39};

  grac_top i_grac_top (.clk, .reset_n, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .cfg_master_trusted, .master_privilege_bits, .chk_valid,
    .chk_addr, .chk_master, .chk_supervisor, .chk_write, .chk_exec,
    .per_module_hit, .per_module_allow, .chk_done, .chk_grant, .chk_error,
    .chk_reserved, .irq);
  grac_master_model i_grac_master_model (.clk, .chk_valid, .chk_addr,
    .chk_master, .chk_supervisor, .chk_write, .chk_exec, .chk_done,
    .chk_grant, .chk_error, .chk_reserved);

  initial begin
    forever #5 clk = ~clk;
  end

  task finish_test;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test

  task cmp(input string n, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : cmp

  task axw(input logic [7:0] a, input logic [31:0] d, input logic t,
           input logic [1:0] er);
    logic aw_t, w_t, b_t;
    int n;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    cfg_master_trusted <= t;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b_t = 1'b0;
    n = 0;
    while (!b_t) begin
      @(negedge clk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      b_t = s_axi_bvalid === 1'b1;
      if (b_t) cmp("bresp", er, s_axi_bresp);
      @(posedge clk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
      if (b_t) s_axi_bready <= 1'b0;
      n++;
      if (n > 50) begin
        n_mismatch++;
        finish_test;
      end
    end
  endtask : axw

  task axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic a_t, r_t;
    int n;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    r_t = 1'b0;
    n = 0;
    while (!r_t) begin
      @(negedge clk);
      a_t = s_axi_arvalid && s_axi_arready;
      r_t = s_axi_rvalid === 1'b1;
      if (r_t) cmp("rdata", ed, s_axi_rdata);
      if (r_t) cmp("rresp", er, s_axi_rresp);
      @(posedge clk);
      if (a_t) s_axi_arvalid <= 1'b0;
      if (r_t) s_axi_rready <= 1'b0;
      n++;
      if (n > 50) begin
        n_mismatch++;
        finish_test;
      end
    end
  endtask : axr

  task acc(input logic [31:0] a, input logic [1:0] m, input logic s, w, x,
           input logic [3:0] e);
    logic [3:0] v;
    i_grac_master_model.access(a, m, s, w, x, v);
    cmp("verdict", e, v);
  endtask : acc

  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 4; i++) axr(8'(i * 4), 32'h0, RESP_OKAY);
    acc(32'h0000_0000, 0, 1, 1, 0, 4'hC);
    acc(32'h0000_0010, 0, 0, 0, 0, 4'hA);
    acc(32'h0000_0010, 0, 1, 0, 1, 4'hA);
    for (int c = 0; c < 16; c++) begin
      axw(OFS_REGION1, 32'(c), 1'b1, RESP_OKAY);
      axr(OFS_REGION1, 32'(c), RESP_OKAY);
      for (int k = 0; k < 6; k++) begin
        // k picks level (sup first) and kind (read, write, execute)
        acc(32'h0400_0000, 0, k < 3, k % 3 == 1, k % 3 == 2,
            RT[c][5 - k] ? 4'hC : 4'hA);
      end
    end
    acc(32'h03FF_FFFF, 0, 0, 0, 1, 4'hA);
    acc(32'h0400_0000, 0, 0, 0, 1, 4'hC);
    acc(32'hC400_0000, 0, 0, 0, 1, 4'hC);
    acc(32'h0800_0000, 0, 1, 0, 0, 4'h9);
    acc(32'h3FFF_FFFC, 0, 1, 1, 0, 4'h9);
    axw(OFS_REGION1, 32'h01, 1'b1, RESP_OKAY);
    @(posedge clk) master_privilege_bits <= 3'b011;
    acc(32'h0400_0000, 2, 1, 0, 0, 4'hA);
    acc(32'h0400_0000, 1, 1, 0, 0, 4'hC);
    @(posedge clk) per_module_hit <= 1'b1;
    per_module_allow <= 1'b1;
    acc(32'h0000_0100, 0, 0, 1, 0, 4'hC);
    @(posedge clk) per_module_allow <= 1'b0;
    acc(32'h0000_0100, 0, 1, 0, 0, 4'hA);
    @(posedge clk) per_module_hit <= 1'b0;
    axr(OFS_EVENT_STATUS, 32'h1, RESP_OKAY);
    @(negedge clk) cmp("irq", 1'b0, irq);
    axw(OFS_EVENT_MASK, 32'h1, 1'b1, RESP_OKAY);
    @(negedge clk) cmp("irq", 1'b1, irq);
    axw(OFS_EVENT_STATUS, 32'h1, 1'b1, RESP_OKAY);
    @(negedge clk) cmp("irq", 1'b0, irq);
    axw(OFS_REGION0, 32'h8C, 1'b1, RESP_OKAY);
    axw(OFS_REGION0, 32'h00, 1'b1, RESP_SLVERR);
    axr(OFS_REGION0, 32'h8C, RESP_OKAY);
    acc(32'h0000_0000, 0, 0, 1, 0, 4'hC);
    axw(OFS_REGION1, 32'h04, 1'b0, RESP_SLVERR);
    axr(OFS_REGION1, 32'h01, RESP_OKAY);
    axr(OFS_EVENT_STATUS, 32'h6, RESP_OKAY);
    axr(8'h10, 32'h0, RESP_DECERR);
    axw(8'h14, 32'h1, 1'b1, RESP_DECERR);
    @(posedge clk) reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    axr(OFS_REGION0, 32'h0, RESP_OKAY);
    acc(32'h0000_0000, 0, 0, 0, 0, 4'hA);
    finish_test;
  end
endmodule : grac_top_tb_top
`default_nettype wire
